/* File: bench/dpr_link_monitor.sv */
`default_nettype none

module dpr_link_monitor (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tap_rst
);
   timeunit 1ns;
   timeprecision 1ns;

   // Port state rebuilt in the core domain, stepped emulation_module per observed tck rise
   typedef struct packed {
      dpr_pkg::dpr_tap_type tap;
      logic                 tck;
      logic                 live;
      logic [4:0]           sh;
      logic [2:0]           rc;
      logic [7:0]           cmd;
      logic                 second;
   } dpr_mon_state_type;

   dpr_mon_state_type st_q;
   dpr_mon_state_type st_d;
   logic              rise;

   assign rise = tck && !st_q.tck;

   function automatic dpr_pkg::dpr_tap_type next_tap(input dpr_pkg::dpr_tap_type s, input logic m);
      case (s)
         dpr_pkg::TAP_RESET:      next_tap = m ? dpr_pkg::TAP_RESET : dpr_pkg::TAP_IDLE;
         dpr_pkg::TAP_IDLE:       next_tap = m ? dpr_pkg::TAP_SEL_DR : dpr_pkg::TAP_IDLE;
         dpr_pkg::TAP_SEL_DR:     next_tap = m ? dpr_pkg::TAP_SEL_IR : dpr_pkg::TAP_CAPTURE_DR;
         dpr_pkg::TAP_CAPTURE_DR: next_tap = m ? dpr_pkg::TAP_EXIT1_DR : dpr_pkg::TAP_SHIFT_DR;
         dpr_pkg::TAP_SHIFT_DR:   next_tap = m ? dpr_pkg::TAP_EXIT1_DR : dpr_pkg::TAP_SHIFT_DR;
         dpr_pkg::TAP_EXIT1_DR:   next_tap = m ? dpr_pkg::TAP_UPDATE_DR : dpr_pkg::TAP_PAUSE_DR;
         dpr_pkg::TAP_PAUSE_DR:   next_tap = m ? dpr_pkg::TAP_EXIT2_DR : dpr_pkg::TAP_PAUSE_DR;
         dpr_pkg::TAP_EXIT2_DR:   next_tap = m ? dpr_pkg::TAP_UPDATE_DR : dpr_pkg::TAP_SHIFT_DR;
         dpr_pkg::TAP_SEL_IR:     next_tap = m ? dpr_pkg::TAP_RESET : dpr_pkg::TAP_CAPTURE_IR;
         dpr_pkg::TAP_CAPTURE_IR: next_tap = m ? dpr_pkg::TAP_EXIT1_IR : dpr_pkg::TAP_SHIFT_IR;
         dpr_pkg::TAP_SHIFT_IR:   next_tap = m ? dpr_pkg::TAP_EXIT1_IR : dpr_pkg::TAP_SHIFT_IR;
         dpr_pkg::TAP_EXIT1_IR:   next_tap = m ? dpr_pkg::TAP_UPDATE_IR : dpr_pkg::TAP_PAUSE_IR;
         dpr_pkg::TAP_PAUSE_IR:   next_tap = m ? dpr_pkg::TAP_EXIT2_IR : dpr_pkg::TAP_PAUSE_IR;
         dpr_pkg::TAP_EXIT2_IR:   next_tap = m ? dpr_pkg::TAP_UPDATE_IR : dpr_pkg::TAP_SHIFT_IR;
         default:                 next_tap = m ? dpr_pkg::TAP_SEL_DR : dpr_pkg::TAP_IDLE;
      endcase
   endfunction : next_tap

   always_comb begin
      st_d = st_q;
      st_d.tck = tck;
      st_d.rc = tap_rst ? st_q.rc + {2'h0, rise} : 3'h0;
      if (rise) begin
         if (st_q.tap == dpr_pkg::TAP_CAPTURE_DR) st_d.sh = 5'h00;
         if (st_q.tap == dpr_pkg::TAP_SHIFT_DR) st_d.sh = st_q.sh + 5'h01;
         if (st_q.tap == dpr_pkg::TAP_SHIFT_DR) st_d.cmd = {tdi, st_q.cmd[7:1]};
         if (st_q.tap == dpr_pkg::TAP_EXIT1_DR && st_q.sh == 5'h08) st_d.second = !st_q.second;
         st_d.tap = next_tap(st_q.tap, tms);
         if (tap_rst) begin
            st_d.tap = dpr_pkg::TAP_RESET;
            st_d.second = 1'b0;
            st_d.live = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) st_q <= '0;
      else st_q <= st_d;
   end

   tck_shape_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(tck) |-> tck[*4] ##1 !tck[*4]) else $error("tck phase length wrong");
   tms_on_fall_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !$fell(tck) |-> $stable(tms)) else $error("tms moved away from a tck fall");
   tdi_on_fall_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !$fell(tck) |-> $stable(tdi)) else $error("tdi moved away from a tck fall");
   tdo_on_rise_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_q.live && !$rose(tck) |-> $stable(tdo)) else $error("tdo moved away from a tck rise");
   rst_tms_a: assert property (@(posedge i_clk) disable iff (i_rst)
      tap_rst |-> tms) else $error("test reset without tms high");
   rst_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(tap_rst) |-> st_q.rc == 3'h5) else $error("test reset not five tck periods");
   dr_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
      rise && st_q.tap == dpr_pkg::TAP_EXIT1_DR |-> st_q.sh == 5'h08 || st_q.sh == 5'h18)
      else $error("data scan length is neither 8 nor 24");
   cmd_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
      rise && st_q.tap == dpr_pkg::TAP_EXIT1_DR && st_q.sh == 5'h08 |->
      st_q.cmd == (st_q.second ? 8'h8A : 8'h8B)) else $error("command code or order wrong");
   upd_next_a: assert property (@(posedge i_clk) disable iff (i_rst)
      rise && st_q.tap == dpr_pkg::TAP_UPDATE_DR && st_q.sh == 5'h08 |-> tms)
      else $error("command update not followed by a data scan");
   end_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
      rise && st_q.tap == dpr_pkg::TAP_UPDATE_DR && st_q.sh == 5'h18 |-> tms == st_q.second)
      else $error("word update routed wrongly");
endmodule : dpr_link_monitor

`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   localparam time DLY   = 5ns;
   localparam int  LIMIT = 20000;

   logic        clk;
   logic        rst;
   logic        trace_en;
   logic        leave;
   logic        int_acc;
   logic        ext_acc;
   logic        start;
   logic [23:0] latch;
   logic [23:0] pbus;
   logic [23:0] int_addr;
   logic [23:0] ext_addr;
   logic [23:0] addr;
   logic        br_n;
   logic        dbg;
   logic        busy;
   logic        done;
   logic [1:0]  status;
   logic [23:0] got_latch;
   logic [23:0] got_bus;
   int          err_total;
   int          tests_run;
   int          cycles;

   dpr_link_if link ();

   dpr_dev i_dpr_dev (.i_clk(clk), .i_rst(rst), .i_address_trace_enable_bit(trace_en), .i_leave_debug(leave),
      .i_instruction_latch_value(latch), .i_program_data_bus_value(pbus), .i_int_access(int_acc),
      .i_int_addr(int_addr), .i_ext_access(ext_acc), .i_ext_addr(ext_addr), .o_addr(addr),
      .o_bus_request_n(br_n), .o_debug_mode(dbg), .link(link));

   dpr_ctl i_dpr_ctl (.i_clk(clk), .i_rst(rst), .i_start(start), .o_busy(busy), .o_done(done),
      .o_core_status_bits(status), .o_instruction_latch_value(got_latch),
      .o_program_data_bus_value(got_bus), .link(link));

   dpr_link_monitor i_dpr_link_monitor (.i_clk(clk), .i_rst(rst), .tck(link.tck), .tms(link.tms),
      .tdi(link.tdi), .tdo(link.tdo), .tap_rst(link.tap_rst));

   always #25ns clk = ~clk;

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_total++;
         $display("timeout after %0d cycles", cycles);
         test_done();
      end
   end

   task automatic check_word(input string what, input logic [23:0] exp, input logic [23:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task automatic check_flag(input string what, input logic exp, input logic got);
      check_word(what, {23'h0, exp}, {23'h0, got});
   endtask : check_flag

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #DLY;
   endtask : tick

   // Accesses are held two edges: one for the registered enable, one for the answer
   task automatic access(input logic te, input logic ia, input logic [23:0] iad, input logic ea,
                         input logic [23:0] ead, input logic [23:0] exp_addr, input logic exp_br);
      trace_en = te;
      int_acc = ia;
      int_addr = iad;
      ext_acc = ea;
      ext_addr = ead;
      tick(2);
      check_word("address lines", exp_addr, addr);
      check_flag("bus request", exp_br, br_n);
   endtask : access

   task automatic readout(input logic [23:0] exp_latch, input logic [23:0] exp_bus);
      int n;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 6000) begin
         tick(1);
         n++;
      end
      check_flag("readout done", 1'b1, done);
      check_flag("busy after readout", 1'b0, busy);
      check_word("core status", 24'h000003, {22'h0, status});
      check_word("latch word", exp_latch, got_latch);
      check_word("bus word", exp_bus, got_bus);
   endtask : readout

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      trace_en = 1'b0;
      leave = 1'b0;
      int_acc = 1'b0;
      ext_acc = 1'b0;
      start = 1'b0;
      latch = 24'hA5C3E1;
      pbus = 24'h5A3C1E;
      int_addr = 24'h000000;
      ext_addr = 24'h000000;
      err_total = 0;
      tests_run = 0;
      cycles = 0;
      repeat (3) @(posedge clk);
      #DLY;
      rst = 1'b0;
      check_word("address after reset", 24'h000000, addr);
      check_flag("bus request after reset", 1'b1, br_n);
      check_flag("debug after reset", 1'b0, dbg);
      check_flag("busy after reset", 1'b0, busy);
      $display("test reset done");

      access(1'b0, 1'b1, 24'h111111, 1'b0, 24'h000000, 24'h000000, 1'b1);
      access(1'b0, 1'b0, 24'h000000, 1'b1, 24'h222222, 24'h222222, 1'b0);
      access(1'b1, 1'b1, 24'h333333, 1'b0, 24'h000000, 24'h333333, 1'b1);
      access(1'b1, 1'b1, 24'h444444, 1'b1, 24'h555555, 24'h555555, 1'b0);
      access(1'b1, 1'b0, 24'h000000, 1'b0, 24'h000000, 24'h555555, 1'b1);
      access(1'b0, 1'b0, 24'h000000, 1'b0, 24'h000000, 24'h555555, 1'b1);
      access(1'b0, 1'b1, 24'h666666, 1'b0, 24'h000000, 24'h555555, 1'b1);
      int_acc = 1'b0;
      $display("test address trace done");

      // Live core values move emulation_module debug is entered; the snapshot must not follow
      fork
         readout(24'hA5C3E1, 24'h5A3C1E);
         begin
            wait (dbg === 1'b1);
            tick(2);
            latch = 24'h0F0F0F;
            pbus = 24'hF0F0F0;
         end
      join
      check_flag("debug held", 1'b1, dbg);
      $display("test first readout done");

      readout(24'hA5C3E1, 24'h5A3C1E);
      $display("test repeated readout done");

      leave = 1'b1;
      tick(1);
      leave = 1'b0;
      tick(2);
      check_flag("debug released", 1'b0, dbg);
      readout(24'h0F0F0F, 24'hF0F0F0);
      $display("test fresh snapshot done");
      test_done();
   end
endmodule : testbench

`default_nettype wire

/* File: hdl/dpr_ctl.sv */
`default_nettype none

module dpr_ctl (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   output logic             o_busy,
   output logic             o_done,
   output logic      [1:0]  o_core_status_bits,
   output logic      [23:0] o_instruction_latch_value,
   output logic      [23:0] o_program_data_bus_value,
   dpr_link_if.ctl          link
);

   typedef struct packed {
      dpr_pkg::dpr_phase_type ph;
      logic [2:0]             div;
      logic                   tck;
      logic                   tms;
      logic                   tdi;
      logic                   trst;
      logic [1:0]             tdo_s;
      logic [4:0]             n;
      logic [2:0]             job;
      logic [3:0]             pre;
      logic [4:0]             pre_len;
      logic [4:0]             len;
      logic [23:0]            dat;
      logic [23:0]            cap;
      logic                   end_bit;
      logic                   go;
      logic                   busy;
      logic                   done;
      logic [1:0]             status;
      logic [23:0]            latch;
      logic [23:0]            bus;
   } dpr_ctl_type;

   dpr_ctl_type q;
   dpr_ctl_type d;
   logic        fall;

   assign fall = (q.div == dpr_pkg::TCK_LAST);

   always_comb begin
      d       = q;
      d.div   = q.div + 3'h1;
      d.tck   = (d.div >= dpr_pkg::TCK_HIGH);
      d.tdo_s = {q.tdo_s[0], link.tdo};
      d.done  = 1'b0;
      if (i_start) begin
         d.go = 1'b1;
      end
      // The device moves tdo on each rise, so each rise after entering Shift, up to and
      // including the one leaving it, takes the bit that the previous rise put out
      if (q.div == dpr_pkg::TCK_RISE
          && ((q.ph == dpr_pkg::PH_SHIFT && q.n != 5'h00) || q.ph == dpr_pkg::PH_UPD)) begin
         d.cap = {q.tdo_s[1], q.cap[23:1]};
      end
      if (fall) begin
         d.tms  = 1'b0;
         d.trst = 1'b0;
         d.tdi  = 1'b0;
         unique case (q.ph)
            dpr_pkg::PH_IDLE: begin
               if (q.go) begin
                  d.go   = 1'b0;
                  d.busy = 1'b1;
                  d.n    = 5'h00;
                  d.ph   = dpr_pkg::PH_RESET;
               end
            end
            dpr_pkg::PH_RESET: begin
               d.tms  = 1'b1;
               d.trst = 1'b1;
               d.n    = q.n + 5'h01;
               if (q.n == dpr_pkg::RESET_BITS - 5'h01) begin
                  d.job     = dpr_pkg::JOB_DEBUG_REQ;
                  d.end_bit = 1'b0;
                  d.ph      = dpr_pkg::PH_END;
               end
            end
            dpr_pkg::PH_END: begin
               d.tms = q.end_bit;
               d.n   = 5'h00;
               if (q.job == dpr_pkg::JOB_DONE) begin
                  d.busy = 1'b0;
                  d.done = 1'b1;
                  d.ph   = dpr_pkg::PH_IDLE;
               end else begin
                  d.ph = dpr_pkg::PH_PRE;
                  unique case (q.job)
                     dpr_pkg::JOB_DEBUG_REQ, dpr_pkg::JOB_POLL: begin
                        d.pre = 4'h3;
                        d.pre_len = 5'h04;
                        d.len = dpr_pkg::IR_BITS;
                        d.dat = {20'h00000, dpr_pkg::IR_DEBUG_REQ};
                     end
                     dpr_pkg::JOB_ENABLE: begin
                        d.pre = 4'h3;
                        d.pre_len = 5'h04;
                        d.len = dpr_pkg::IR_BITS;
                        d.dat = {20'h00000, dpr_pkg::IR_ENABLE};
                     end
                     dpr_pkg::JOB_CMD_LATCH: begin
                        d.pre = 4'h1;
                        d.pre_len = 5'h03;
                        d.len = dpr_pkg::CMD_BITS;
                        d.dat = {16'h0000, dpr_pkg::CMD_READ_INSTR_LATCH};
                     end
                     dpr_pkg::JOB_CMD_BUS: begin
                        d.pre = 4'h0;
                        d.pre_len = 5'h02;
                        d.len = dpr_pkg::CMD_BITS;
                        d.dat = {16'h0000, dpr_pkg::CMD_READ_PROG_BUS};
                     end
                     default: begin
                        d.pre = 4'h0;
                        d.pre_len = 5'h02;
                        d.len = dpr_pkg::WORD_BITS;
                        d.dat = 24'h000000;
                     end
                  endcase
               end
            end
            dpr_pkg::PH_PRE: begin
               d.tms = q.pre[q.n[1:0]];
               d.n   = q.n + 5'h01;
               if (q.n == q.pre_len - 5'h01) begin
                  d.n  = 5'h00;
                  d.ph = dpr_pkg::PH_SHIFT;
               end
            end
            dpr_pkg::PH_SHIFT: begin
               d.tdi = q.dat[0];
               d.dat = {1'b0, q.dat[23:1]};
               d.tms = (q.n == q.len - 5'h01);
               d.n   = q.n + 5'h01;
               if (d.tms) begin
                  d.ph = dpr_pkg::PH_UPD;
               end
            end
            dpr_pkg::PH_UPD: begin
               d.tms     = 1'b1;
               d.ph      = dpr_pkg::PH_END;
               d.job     = q.job + 3'h1;
               d.end_bit = 1'b0;
               unique case (q.job)
                  dpr_pkg::JOB_POLL: begin
                     d.status = q.cap[23:22];
                     if (q.cap[23:22] != dpr_pkg::STATUS_DEBUG) begin
                        d.job = dpr_pkg::JOB_POLL;
                     end
                  end
                  dpr_pkg::JOB_CMD_LATCH, dpr_pkg::JOB_CMD_BUS: begin
                     d.end_bit = 1'b1;
                  end
                  dpr_pkg::JOB_READ_LATCH: begin
                     d.latch   = q.cap;
                     d.end_bit = 1'b1;
                  end
                  dpr_pkg::JOB_READ_BUS: begin
                     d.bus = q.cap;
                  end
                  default: begin
                  end
               endcase
            end
            default: begin
               d.ph = dpr_pkg::PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign link.tck                  = q.tck;
   assign link.tms                  = q.tms;
   assign link.tdi                  = q.tdi;
   assign link.tap_rst              = q.trst;
   assign o_busy                    = q.busy;
   assign o_done                    = q.done;
   assign o_core_status_bits        = q.status;
   assign o_instruction_latch_value = q.latch;
   assign o_program_data_bus_value  = q.bus;

endmodule : dpr_ctl

`default_nettype wire

/* File: hdl/dpr_dev.sv */
`default_nettype none

module dpr_dev (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_address_trace_enable_bit,
   input  wire logic        i_leave_debug,
   input  wire logic [23:0] i_instruction_latch_value,
   input  wire logic [23:0] i_program_data_bus_value,
   input  wire logic        i_int_access,
   input  wire logic [23:0] i_int_addr,
   input  wire logic        i_ext_access,
   input  wire logic [23:0] i_ext_addr,
   output logic      [23:0] o_addr,
   output logic             o_bus_request_n,
   output logic             o_debug_mode,
   dpr_link_if.dev          link
);

   // Core clock domain
   typedef struct packed {
      logic [2:0]  req_s;
      logic        debug;
      logic [23:0] latch_sv;
      logic [23:0] bus_sv;
      logic        trace_en;
      logic [23:0] addr;
      logic        br_n;
   } dpr_core_type;

   // Link clock domain
   typedef struct packed {
      dpr_pkg::dpr_tap_type tap;
      logic [3:0]           ir;
      logic [3:0]           irs;
      logic [23:0]          sh;
      logic                 loaded;
      logic                 tdo;
      logic                 req_tgl;
      logic                 emu_en;
      logic [1:0]           st_s;
   } dpr_tck_type;

   localparam dpr_core_type CORE_RST = '{
      req_s    : 3'h0,
      debug    : 1'h0,
      latch_sv : 24'h000000,
      bus_sv   : 24'h000000,
      trace_en : 1'h0,
      addr     : 24'h000000,
      br_n     : dpr_pkg::BR_N_RST
   };

   localparam dpr_tck_type TCK_RST = '{
      tap     : dpr_pkg::TAP_RESET,
      ir      : dpr_pkg::IR_RST,
      irs     : 4'h0,
      sh      : 24'h000000,
      loaded  : 1'h0,
      tdo     : 1'h0,
      req_tgl : 1'h0,
      emu_en  : 1'h0,
      st_s    : 2'h0
   };

   dpr_core_type c_q;
   dpr_core_type c_d;
   dpr_tck_type  t_q;
   dpr_tck_type  t_d;
   logic [1:0]   status;
   logic [7:0]   cmd;

   function automatic dpr_pkg::dpr_tap_type tap_next(input dpr_pkg::dpr_tap_type s, input logic tms);
      dpr_pkg::dpr_tap_type n;
      n = s;
      unique case (s)
         dpr_pkg::TAP_RESET:      n = tms ? dpr_pkg::TAP_RESET     : dpr_pkg::TAP_IDLE;
         dpr_pkg::TAP_IDLE:       n = tms ? dpr_pkg::TAP_SEL_DR    : dpr_pkg::TAP_IDLE;
         dpr_pkg::TAP_SEL_DR:     n = tms ? dpr_pkg::TAP_SEL_IR    : dpr_pkg::TAP_CAPTURE_DR;
         dpr_pkg::TAP_CAPTURE_DR: n = tms ? dpr_pkg::TAP_EXIT1_DR  : dpr_pkg::TAP_SHIFT_DR;
         dpr_pkg::TAP_SHIFT_DR:   n = tms ? dpr_pkg::TAP_EXIT1_DR  : dpr_pkg::TAP_SHIFT_DR;
         dpr_pkg::TAP_EXIT1_DR:   n = tms ? dpr_pkg::TAP_UPDATE_DR : dpr_pkg::TAP_PAUSE_DR;
         dpr_pkg::TAP_PAUSE_DR:   n = tms ? dpr_pkg::TAP_EXIT2_DR  : dpr_pkg::TAP_PAUSE_DR;
         dpr_pkg::TAP_EXIT2_DR:   n = tms ? dpr_pkg::TAP_UPDATE_DR : dpr_pkg::TAP_SHIFT_DR;
         dpr_pkg::TAP_UPDATE_DR:  n = tms ? dpr_pkg::TAP_SEL_DR    : dpr_pkg::TAP_IDLE;
         dpr_pkg::TAP_SEL_IR:     n = tms ? dpr_pkg::TAP_RESET     : dpr_pkg::TAP_CAPTURE_IR;
         dpr_pkg::TAP_CAPTURE_IR: n = tms ? dpr_pkg::TAP_EXIT1_IR  : dpr_pkg::TAP_SHIFT_IR;
         dpr_pkg::TAP_SHIFT_IR:   n = tms ? dpr_pkg::TAP_EXIT1_IR  : dpr_pkg::TAP_SHIFT_IR;
         dpr_pkg::TAP_EXIT1_IR:   n = tms ? dpr_pkg::TAP_UPDATE_IR : dpr_pkg::TAP_PAUSE_IR;
         dpr_pkg::TAP_PAUSE_IR:   n = tms ? dpr_pkg::TAP_EXIT2_IR  : dpr_pkg::TAP_PAUSE_IR;
         dpr_pkg::TAP_EXIT2_IR:   n = tms ? dpr_pkg::TAP_UPDATE_IR : dpr_pkg::TAP_SHIFT_IR;
         dpr_pkg::TAP_UPDATE_IR:  n = tms ? dpr_pkg::TAP_SEL_DR    : dpr_pkg::TAP_IDLE;
      endcase
      return n;
   endfunction : tap_next

   always_comb begin
      c_d = c_q;
      // Request toggle crosses from the link side; bit 0 feeds only bit 1
      c_d.req_s = {c_q.req_s[1:0], t_q.req_tgl};
      if ((c_q.req_s[2] ^ c_q.req_s[1]) && !c_q.debug) begin
         c_d.debug    = 1'b1;
         // Snapshot taken emulation_module on entry and frozen while halted
         c_d.latch_sv = i_instruction_latch_value;
         c_d.bus_sv   = i_program_data_bus_value;
      end else if (i_leave_debug) begin
         c_d.debug = 1'b0;
      end
      c_d.trace_en = i_address_trace_enable_bit;
      if (i_ext_access) begin
         c_d.addr = i_ext_addr;
         c_d.br_n = 1'b0;
      end else if (c_q.trace_en && i_int_access) begin
         c_d.addr = i_int_addr;
         c_d.br_n = 1'b1;
      end else begin
         c_d.br_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         c_q <= CORE_RST;
      end else begin
         c_q <= c_d;
      end
   end

   assign o_addr          = c_q.addr;
   assign o_bus_request_n = c_q.br_n;
   assign o_debug_mode    = c_q.debug;

   // Both status bits report the synchronised debug state
   assign status = {t_q.st_s[1], t_q.st_s[1]};
   assign cmd    = t_q.sh[23:16];

   always_comb begin
      t_d      = t_q;
      t_d.st_s = {t_q.st_s[0], c_q.debug};
      t_d.tap  = tap_next(t_q.tap, link.tms);
      unique case (t_q.tap)
         dpr_pkg::TAP_RESET: begin
            t_d.ir     = dpr_pkg::IR_RST;
            t_d.emu_en = 1'b0;
            t_d.loaded = 1'b0;
         end
         dpr_pkg::TAP_CAPTURE_IR: begin
            t_d.irs = {status, dpr_pkg::IR_CAP_LOW};
         end
         dpr_pkg::TAP_SHIFT_IR: begin
            t_d.irs = {link.tdi, t_q.irs[3:1]};
         end
         dpr_pkg::TAP_UPDATE_IR: begin
            t_d.ir = t_q.irs;
            if (t_q.irs == dpr_pkg::IR_DEBUG_REQ) begin
               t_d.req_tgl = ~t_q.req_tgl;
            end
            if (t_q.irs == dpr_pkg::IR_ENABLE) begin
               t_d.emu_en = 1'b1;
            end
         end
         dpr_pkg::TAP_CAPTURE_DR: begin
            // A loaded pipeline word survives capture so it can be scanned out
            if (!t_q.loaded) begin
               t_d.sh = '0;
            end
         end
         dpr_pkg::TAP_SHIFT_DR: begin
            t_d.sh = {link.tdi, t_q.sh[23:1]};
         end
         dpr_pkg::TAP_UPDATE_DR: begin
            t_d.loaded = 1'b0;
            // Saved words are stable while the core is halted, so reading them here is safe
            if (!t_q.loaded && t_q.emu_en && t_q.ir == dpr_pkg::IR_ENABLE && status == dpr_pkg::STATUS_DEBUG) begin
               if (cmd == dpr_pkg::CMD_READ_INSTR_LATCH) begin
                  t_d.sh     = c_q.latch_sv;
                  t_d.loaded = 1'b1;
               end else if (cmd == dpr_pkg::CMD_READ_PROG_BUS) begin
                  t_d.sh     = c_q.bus_sv;
                  t_d.loaded = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      t_d.tdo = (t_d.tap == dpr_pkg::TAP_SHIFT_IR) ? t_d.irs[0] : t_d.sh[0];
   end

   always_ff @(posedge link.tck) begin
      if (link.tap_rst) begin
         t_q <= TCK_RST;
      end else begin
         t_q <= t_d;
      end
   end

   assign link.tdo = t_q.tdo;

endmodule : dpr_dev

`default_nettype wire

/* File: hdl/dpr_link_if.sv */
`default_nettype none

interface dpr_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tap_rst;

   modport ctl (output tck, output tms, output tdi, output tap_rst, input tdo);
   modport dev (input tck, input tms, input tdi, input tap_rst, output tdo);
endinterface : dpr_link_if

`default_nettype wire

/* File: hdl/dpr_pkg.sv */
`default_nettype none

package dpr_pkg;

   localparam int unsigned DATA_W = 24;
   localparam int unsigned IR_W   = 4;

   // Test instruction codes
   localparam logic [3:0] IR_DEBUG_REQ = 4'h7;
   localparam logic [3:0] IR_ENABLE    = 4'h6;
   localparam logic [3:0] IR_RST       = 4'hF;
   localparam logic [1:0] IR_CAP_LOW   = 2'h1;
   localparam logic [1:0] STATUS_DEBUG = 2'h3;

   // Emulation commands, sent least significant bit first
   localparam logic [7:0] CMD_READ_INSTR_LATCH = 8'h8B;
   localparam logic [7:0] CMD_READ_PROG_BUS    = 8'h8A;

   // Link clock divider: period of eight system clocks
   localparam logic [2:0] TCK_RISE = 3'h3;
   localparam logic [2:0] TCK_HIGH = 3'h4;
   localparam logic [2:0] TCK_LAST = 3'h7;

   localparam logic [4:0] RESET_BITS  = 5'h05;
   localparam logic [4:0] CMD_BITS    = 5'h08;
   localparam logic [4:0] WORD_BITS   = 5'h18;
   localparam logic [4:0] IR_BITS     = 5'h04;
   localparam logic       BR_N_RST    = 1'h1;

   // Controller job sequence
   localparam logic [2:0] JOB_DEBUG_REQ  = 3'h0;
   localparam logic [2:0] JOB_POLL       = 3'h1;
   localparam logic [2:0] JOB_ENABLE     = 3'h2;
   localparam logic [2:0] JOB_CMD_LATCH  = 3'h3;
   localparam logic [2:0] JOB_READ_LATCH = 3'h4;
   localparam logic [2:0] JOB_CMD_BUS    = 3'h5;
   localparam logic [2:0] JOB_READ_BUS   = 3'h6;
   localparam logic [2:0] JOB_DONE       = 3'h7;

   typedef enum logic [3:0] {
      TAP_RESET      = 4'h0,
      TAP_IDLE       = 4'h1,
      TAP_SEL_DR     = 4'h2,
      TAP_CAPTURE_DR = 4'h3,
      TAP_SHIFT_DR   = 4'h4,
      TAP_EXIT1_DR   = 4'h5,
      TAP_PAUSE_DR   = 4'h6,
      TAP_EXIT2_DR   = 4'h7,
      TAP_UPDATE_DR  = 4'h8,
      TAP_SEL_IR     = 4'h9,
      TAP_CAPTURE_IR = 4'hA,
      TAP_SHIFT_IR   = 4'hB,
      TAP_EXIT1_IR   = 4'hC,
      TAP_PAUSE_IR   = 4'hD,
      TAP_EXIT2_IR   = 4'hE,
      TAP_UPDATE_IR  = 4'hF
   } dpr_tap_type;

   typedef enum logic [2:0] {
      PH_IDLE  = 3'h0,
      PH_RESET = 3'h1,
      PH_PRE   = 3'h2,
      PH_SHIFT = 3'h3,
      PH_UPD   = 3'h4,
      PH_END   = 3'h5
   } dpr_phase_type;

endpackage : dpr_pkg

`default_nettype wire
